/* common/ics_pkg.sv */
// Constants and carrier types of the two-wire bus control and status registers
package ics_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CONTROL  = 8'h18;
  localparam logic [7:0] IDX_STATUS1  = 8'h19;
  localparam logic [7:0] IDX_STATUS2  = 8'h1A;
  localparam logic [7:0] IDX_OWN_ADDR = 8'h1C;
  localparam logic [7:0] IDX_DATA     = 8'h1E;

  // ==========================================================================
  // Control register fields
  localparam int CR_ON    = 5;
  localparam int CR_GC    = 4;
  localparam int CR_START = 3;
  localparam int CR_ACK   = 2;
  localparam int CR_STOP  = 1;
  localparam int CR_ITE   = 0;

  // ==========================================================================
  // First status register fields
  localparam int S1_EVF  = 7;
  localparam int S1_HDR  = 6;
  localparam int S1_DIR  = 5;
  localparam int S1_BUSY = 4;
  localparam int S1_BTF  = 3;
  localparam int S1_SLAVE_ADDR_MATCH = 2;
  localparam int S1_MSTR = 1;
  localparam int S1_SB   = 0;

  // ==========================================================================
  // Second status register fields
  localparam int S2_AF   = 4;
  localparam int S2_STOP = 3;
  localparam int S2_LOST_CONTENTION = 2;
  localparam int S2_MISPLACED_CONDITION_FLAG = 1;
  localparam int S2_BROADCAST_ADDR_SEEN = 0;

  // ==========================================================================
  // Reset values and special addresses
  localparam logic [7:0] CR_RST   = 8'h00;
  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] GC_ADDR  = 8'h00;
  localparam logic [7:0] IGN_ADDR = 8'h01;

  // ==========================================================================
  // Events from the bit engine, one-cycle pulses except in_byte and rx_byte
  typedef struct packed {
    logic       byte_done;
    logic       byte_sent;
    logic       addr_rx;
    logic [7:0] rx_byte;
    logic       nack;
    logic       arb_lost;
    logic       ack_slot_rx;
    logic       start_sent;
    logic       stop_sent;
    logic       hdr_sent;
    logic       addr_sent;
    logic       in_byte;
  } ics_ev_t;

  // Controls to the bit engine
  typedef struct packed {
    logic       on;
    logic       gc_en;
    logic       start_req;
    logic       ack_en;
    logic       stop_req;
    logic       master;
    logic       busy;
    logic       ack_give;
    logic       release_lines;
    logic       tx_load;
    logic       rx_taken;
    logic [7:0] own_addr;
    logic [7:0] tx_byte;
  } ics_ctl_t;

endpackage : ics_pkg

/* core/ics_regs.sv */
// Control and status registers of a multimaster two-wire bus interface
// What this block does
// - disable clears all but stop, busy, own address and data, releases outputs
// - broadcast acks 00h, ignores 01h
// - start request, cleared once start sent
// - acknowledge enable gates returned acknowledge
// - master stop request cleared after stop sent
// - slave stop releases lines; software clears it
// - clock held low while key flags pending
// - summary flag is OR of all events
// - header flag clears after status-two read, data write
// - direction flag follows byte-done flag
// - busy set on start, cleared on stop or error
// - busy frozen while disabled
// - byte-done set on ack clock, two-step clear
// - address-match set on match, cleared by status read
// - master role set by start, cleared on stop/loss
// - start-sent cleared by status read, data write
// - acknowledge failure cleared by status-two read
// - slave stop after acknowledge sets stop flag
// - arbitration loss flagged, none during master-rx ack
// - misplaced start or stop sets bus error
// - broadcast-seen flag cleared on stop or disable
// - one interrupt from enabled pending events
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module ics_regs #(
  parameter int ADR_W = 10
) (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output var  logic              scl_out,
  output var  logic              scl_oe,
  input  wire ics_pkg::ics_ev_t  ev,
  output var  ics_pkg::ics_ctl_t ctl,
  output var  logic              irq
);

  if (ADR_W < 10) begin : g_adr_check
    $error("ADR_W must be at least 10");
  end

  // ==========================================================================
  // Bus decode
  logic       req;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       hit_cr;
  logic       hit_s1;
  logic       hit_s2;
  logic       hit_own;
  logic       hit_dr;
  logic [7:0] wd;

  assign req     = wb_cyc_i & wb_stb_i;
  assign acc     = req & ~wb_ack_o;
  assign wr      = acc & wb_we_i & wb_sel_i[0];
  assign rd      = acc & ~wb_we_i;
  assign idx     = wb_adr_i[9:2];
  assign hit_cr  = idx == ics_pkg::IDX_CONTROL;
  assign hit_s1  = idx == ics_pkg::IDX_STATUS1;
  assign hit_s2  = idx == ics_pkg::IDX_STATUS2;
  assign hit_own = idx == ics_pkg::IDX_OWN_ADDR;
  assign hit_dr  = idx == ics_pkg::IDX_DATA;
  assign wd      = wb_dat_i[7:0];

  // ==========================================================================
  // State
  logic       on;
  logic       gc_en;
  logic       start_req;
  logic       ack_en;
  logic       stop_req;
  logic       irq_enable;
  logic [7:0] own_addr;
  logic [7:0] data_reg;
  logic       hdr;
  logic       dir;
  logic       busy;
  logic       byte_done_flag;
  logic       slave_addr_match;
  logic       master;
  logic       sb;
  logic       ev6;
  logic       af;
  logic       bus_end_detected;
  logic       lost_contention;
  logic       misplaced_condition_flag;
  logic       broadcast_addr_seen;
  logic       arm1;
  logic       arm2;
  logic       acked;
  logic       ack_give;
  logic       tx_load;
  logic       rx_taken;
  logic       release_lines;

  // ==========================================================================
  // Pin synchronisers and condition detection
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_prev;
  logic       sda_prev;
  logic       start_det;
  logic       stop_det;

  always_ff @(posedge clock) begin
    if (srst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (ce) begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign start_det = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_det  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  // ==========================================================================
  // Access strobes for the clearing sequences
  logic s1_rd;
  logic s2_rd;
  logic cr_wr;
  logic dr_wr;
  logic dr_rd;
  logic addr_hit;
  logic gc_hit;
  logic event_pending;
  logic misplaced;

  assign s1_rd = rd & hit_s1;
  assign s2_rd = rd & hit_s2;
  assign cr_wr = wr & hit_cr;
  assign dr_wr = wr & hit_dr;
  assign dr_rd = rd & hit_dr;

  assign gc_hit   = gc_en & (ev.rx_byte == ics_pkg::GC_ADDR);
  assign addr_hit = ev.addr_rx & (gc_hit | (ev.rx_byte != ics_pkg::IGN_ADDR
                    && ev.rx_byte[7:1] == own_addr[7:1]));

  assign misplaced = (start_det | stop_det) & ev.in_byte;

  assign event_pending = byte_done_flag | slave_addr_match | sb | af | bus_end_detected | lost_contention | misplaced_condition_flag | hdr | ev6;

  // ==========================================================================
  // Control register
  always_ff @(posedge clock) begin
    if (srst) begin
      on        <= 1'b0;
      gc_en     <= 1'b0;
      start_req <= 1'b0;
      ack_en    <= 1'b0;
      stop_req  <= 1'b0;
      irq_enable       <= 1'b0;
    end else if (ce) begin
      if (cr_wr) begin
        on       <= wd[ics_pkg::CR_ON];
        stop_req <= wd[ics_pkg::CR_STOP];
        if (on && wd[ics_pkg::CR_ON]) begin
          gc_en     <= wd[ics_pkg::CR_GC];
          start_req <= wd[ics_pkg::CR_START];
          ack_en    <= wd[ics_pkg::CR_ACK];
          irq_enable       <= wd[ics_pkg::CR_ITE];
        end
      end
      if (on && ev.start_sent) begin
        start_req <= 1'b0;
      end
      if (on && master && ev.stop_sent) begin
        stop_req <= 1'b0;
      end
      if (!on || (cr_wr && !wd[ics_pkg::CR_ON])) begin
        gc_en     <= 1'b0;
        start_req <= 1'b0;
        ack_en    <= 1'b0;
        irq_enable       <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Own address and data registers
  always_ff @(posedge clock) begin
    if (srst) begin
      own_addr <= ics_pkg::OWN_RST;
      data_reg <= ics_pkg::DATA_RST;
    end else if (ce) begin
      if (wr && hit_own) begin
        own_addr <= wd;
      end
      if (dr_wr) begin
        data_reg <= wd;
      end else if (ev.byte_done && !ev.byte_sent) begin
        data_reg <= ev.rx_byte;
      end
    end
  end

  // ==========================================================================
  // Clearing sequence tracking
  always_ff @(posedge clock) begin
    if (srst) begin
      arm1 <= 1'b0;
      arm2 <= 1'b0;
    end else if (ce) begin
      if (!on) begin
        arm1 <= 1'b0;
        arm2 <= 1'b0;
      end else begin
        if (s1_rd) begin
          arm1 <= 1'b1;
        end else if (dr_wr || dr_rd || cr_wr) begin
          arm1 <= 1'b0;
        end
        if (s2_rd) begin
          arm2 <= 1'b1;
        end else if (dr_wr || dr_rd || cr_wr) begin
          arm2 <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Bus busy tracking, frozen while disabled
  always_ff @(posedge clock) begin
    if (srst) begin
      busy <= 1'b0;
    end else if (ce && on) begin
      if (start_det && !misplaced) begin
        busy <= 1'b1;
      end else if (stop_det || misplaced) begin
        busy <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Status flags; in each flag the set is written last so it wins
  always_ff @(posedge clock) begin
    if (srst) begin
      hdr    <= 1'b0;
      dir    <= 1'b0;
      byte_done_flag    <= 1'b0;
      slave_addr_match   <= 1'b0;
      master <= 1'b0;
      sb     <= 1'b0;
      ev6    <= 1'b0;
      af     <= 1'b0;
      bus_end_detected  <= 1'b0;
      lost_contention   <= 1'b0;
      misplaced_condition_flag   <= 1'b0;
      broadcast_addr_seen   <= 1'b0;
      acked  <= 1'b0;
    end else if (ce) begin
      if (!on) begin
        hdr    <= 1'b0;
        dir    <= 1'b0;
        byte_done_flag    <= 1'b0;
        slave_addr_match   <= 1'b0;
        master <= 1'b0;
        sb     <= 1'b0;
        ev6    <= 1'b0;
        af     <= 1'b0;
        bus_end_detected  <= 1'b0;
        lost_contention   <= 1'b0;
        misplaced_condition_flag   <= 1'b0;
        broadcast_addr_seen   <= 1'b0;
        acked  <= 1'b0;
      end else begin
        // Clears by software sequence or bus condition
        if (arm2 && dr_wr) hdr <= 1'b0;
        if (arm1 && (dr_wr || dr_rd)) begin
          byte_done_flag <= 1'b0;
          dir <= 1'b0;
        end
        if (s1_rd) slave_addr_match <= 1'b0;
        if (arm1 && dr_wr) sb <= 1'b0;
        if (arm1 && cr_wr) ev6 <= 1'b0;
        if (s2_rd) begin
          af   <= 1'b0;
          lost_contention <= 1'b0;
          misplaced_condition_flag <= 1'b0;
        end
        if (s2_rd) bus_end_detected <= 1'b0;
        if (stop_det) begin
          master <= 1'b0;
          broadcast_addr_seen   <= 1'b0;
          dir    <= 1'b0;
          acked  <= 1'b0;
        end
        if (start_det) acked <= 1'b0;
        if (ev.arb_lost && !ev.ack_slot_rx) begin
          master <= 1'b0;
          dir    <= 1'b0;
        end
        // Sets by hardware events and the start write
        if (ev.hdr_sent && master) hdr <= 1'b1;
        if (ev.byte_done) begin
          byte_done_flag <= 1'b1;
          dir <= ev.byte_sent;
          if (!ev.byte_sent) acked <= 1'b1;
        end
        if (addr_hit && !master) begin
          slave_addr_match  <= 1'b1;
          acked <= ack_en;
          if (gc_hit) broadcast_addr_seen <= 1'b1;
        end
        if (cr_wr && on && wd[ics_pkg::CR_START]) master <= 1'b1;
        if (ev.start_sent) sb <= 1'b1;
        if (ev.addr_sent && master) ev6 <= 1'b1;
        if (ev.nack) af <= 1'b1;
        if (stop_det && !master && ack_en && acked) bus_end_detected <= 1'b1;
        if (ev.arb_lost && !ev.ack_slot_rx && master) lost_contention <= 1'b1;
        if (misplaced) misplaced_condition_flag <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Engine controls
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_give      <= 1'b0;
      tx_load       <= 1'b0;
      rx_taken      <= 1'b0;
      release_lines <= 1'b0;
    end else if (ce) begin
      ack_give      <= on & ack_en;
      tx_load       <= on & dr_wr;
      rx_taken      <= on & dr_rd;
      release_lines <= on & ~master & stop_req & byte_done_flag;
    end
  end

  // ==========================================================================
  // Pin outputs and interrupt
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
      irq     <= 1'b0;
    end else if (ce) begin
      scl_out <= 1'b0;
      scl_oe  <= on & (hdr | sb | byte_done_flag | slave_addr_match | ev6);
      irq     <= on & irq_enable & event_pending;
    end
  end

  // ==========================================================================
  // Register read and bus answer
  logic [7:0] next_rd;

  always_comb begin
    next_rd = 8'h00;
    if (hit_cr) begin
      next_rd[ics_pkg::CR_ON]    = on;
      next_rd[ics_pkg::CR_GC]    = gc_en;
      next_rd[ics_pkg::CR_START] = start_req;
      next_rd[ics_pkg::CR_ACK]   = ack_en;
      next_rd[ics_pkg::CR_STOP]  = stop_req;
      next_rd[ics_pkg::CR_ITE]   = irq_enable;
    end else if (hit_s1) begin
      next_rd[ics_pkg::S1_EVF]  = event_pending;
      next_rd[ics_pkg::S1_HDR]  = hdr;
      next_rd[ics_pkg::S1_DIR]  = dir & byte_done_flag;
      next_rd[ics_pkg::S1_BUSY] = busy;
      next_rd[ics_pkg::S1_BTF]  = byte_done_flag;
      next_rd[ics_pkg::S1_SLAVE_ADDR_MATCH] = slave_addr_match;
      next_rd[ics_pkg::S1_MSTR] = master;
      next_rd[ics_pkg::S1_SB]   = sb;
    end else if (hit_s2) begin
      next_rd[ics_pkg::S2_AF]   = af;
      next_rd[ics_pkg::S2_STOP] = bus_end_detected;
      next_rd[ics_pkg::S2_LOST_CONTENTION] = lost_contention;
      next_rd[ics_pkg::S2_MISPLACED_CONDITION_FLAG] = misplaced_condition_flag;
      next_rd[ics_pkg::S2_BROADCAST_ADDR_SEEN] = broadcast_addr_seen;
    end else if (hit_own) begin
      next_rd = own_addr;
    end else if (hit_dr) begin
      next_rd = data_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= acc;
      if (rd) begin
        wb_dat_o <= {24'h00_0000, next_rd};
      end
    end
  end

  // ==========================================================================
  // Control bundle, all fields from flip-flops
  assign ctl.on            = on;
  assign ctl.gc_en         = gc_en;
  assign ctl.start_req     = start_req;
  assign ctl.ack_en        = ack_en;
  assign ctl.stop_req      = stop_req;
  assign ctl.master        = master;
  assign ctl.busy          = busy;
  assign ctl.ack_give      = ack_give;
  assign ctl.release_lines = release_lines;
  assign ctl.tx_load       = tx_load;
  assign ctl.rx_taken      = rx_taken;
  assign ctl.own_addr      = own_addr;
  assign ctl.tx_byte       = data_reg;

endmodule : ics_regs

`default_nettype wire

/* verification/ics_bus_peer.sv */
// Behavioural model of another party driving the two-wire bus lines
`timescale 1ns/100ps
`default_nettype none
module ics_bus_peer (
  output var logic scl,
  output var logic sda
);
  // Lines idle at the pull-up level; clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // First step lands between system clock edges
  task automatic open_frame();
    #110 sda = 1'b0;
    repeat (5) begin
      #100 scl = ~scl;
    end
  endtask : open_frame
  task automatic close_frame();
    #110 scl = 1'b1;
    #100 sda = 1'b1;
  endtask : close_frame
endmodule : ics_bus_peer
`default_nettype wire

/* verification/ics_regs_checker.sv */
// Concurrent checks on the ports of the two-wire bus register block
`timescale 1ns/100ps
`default_nettype none
module ics_regs_checker (
  input wire logic              clock,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              scl_oe,
  input wire ics_pkg::ics_ev_t  ev,
  input wire ics_pkg::ics_ctl_t ctl,
  input wire logic              irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ==========================================================================
  // Properties
  property p_ack_next; ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_off_clear; ce && !ctl.on |=> !(ctl.gc_en || ctl.ack_en || ctl.start_req || ctl.master); endproperty
  a_off_clear: assert property (p_off_clear) else $error("control kept while off");
  property p_off_quiet; ce && !ctl.on ##1 ce && !ctl.on |=> !scl_oe && !irq; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("output active while off");
  property p_busy_hold; ce && !ctl.on ##1 ce && !ctl.on |-> $stable(ctl.busy); endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy moved while off");
  property p_start_done; ce && ev.start_sent |=> !ctl.start_req; endproperty
  a_start_done: assert property (p_start_done) else $error("start request kept");
  property p_stop_done; ce && ctl.master && ev.stop_sent |=> !ctl.stop_req; endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop request kept");
  property p_arb_slave; ce && ev.arb_lost && !ev.ack_slot_rx |=> !ctl.master; endproperty
  a_arb_slave: assert property (p_arb_slave) else $error("master kept after loss");
  property p_ack_give; ce |=> ctl.ack_give == $past(ctl.on && ctl.ack_en); endproperty
  a_ack_give: assert property (p_ack_give) else $error("ack give wrong");
  property p_sb_hold; ce && ctl.on && ev.start_sent |-> ##2 scl_oe; endproperty
  a_sb_hold: assert property (p_sb_hold) else $error("clock not held");
  c_start: cover property (ev.start_sent);
  c_arb: cover property (ev.arb_lost && !ev.ack_slot_rx);
  c_reon: cover property (!ctl.on ##1 ctl.on);
endmodule : ics_regs_checker
bind ics_regs ics_regs_checker ics_regs_checker_inst (.clock(clock), .srst(srst), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .scl_oe(scl_oe),
  .ev(ev), .ctl(ctl), .irq(irq));
`default_nettype wire

/* verification/test_ics_regs.sv */
// Self-checking bench for the two-wire bus register block
`timescale 1ns/100ps
`default_nettype none
module test_ics_regs;
  localparam logic [7:0] RC = ics_pkg::IDX_CONTROL;
  localparam logic [7:0] R1 = ics_pkg::IDX_STATUS1;
  localparam logic [7:0] R2 = ics_pkg::IDX_STATUS2;
  localparam logic [7:0] RD = ics_pkg::IDX_DATA;
  logic              clock = 1'b0;
  logic              srst = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [9:0]        wb_adr_i = 10'h000;
  logic [31:0]       wb_dat_i = 32'h0000_0000;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              scl;
  logic              sda;
  logic              scl_oe;
  logic              scl_out;
  logic              irq;
  ics_pkg::ics_ev_t  ev = '0;
  ics_pkg::ics_ctl_t ctl;
  int                failures = 0;
  int                tests_run = 0;
  int                cycles = 0;
  // Open-drain clock line: low when the device pulls it
  wire               scl_line = scl & ~scl_oe;
  ics_regs ics_regs_inst (
    .clock(clock), .srst(srst), .ce(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_in(scl_line), .sda_in(sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .ev(ev), .ctl(ctl), .irq(irq));
  ics_bus_peer ics_bus_peer_inst (.scl(scl), .sda(sda));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ==========================================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, i, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input string n);
    logic [7:0] q;
    wb(1'b0, i, 8'h00, q);
    check(n, q, e);
  endtask : rd
  task automatic pulse(input ics_pkg::ics_ev_t e);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= '0;
  endtask : pulse
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rd(RC, 8'h00, "cr");
    rd(R1, 8'h00, "s1");
    rd(R2, 8'h00, "s2");
    wr(8'h1B, 8'hFF);
    rd(8'h1B, 8'h00, "unmapped");
    $display("test reset done");
    wr(RC, 8'h3D);
    rd(RC, 8'h20, "cr first");
    wr(RC, 8'h35);
    rd(RC, 8'h35, "cr second");
    ics_bus_peer_inst.open_frame();
    repeat (8) @(posedge clock);
    rd(R1, 8'h10, "busy");
    ics_bus_peer_inst.close_frame();
    repeat (4) @(posedge clock);
    ev <= '{in_byte: 1'b1, default: '0};
    ics_bus_peer_inst.open_frame();
    rd(R1, 8'h80, "s1 misplaced_condition_flag");
    rd(R2, 8'h02, "misplaced_condition_flag");
    rd(R2, 8'h00, "misplaced_condition_flag clr");
    ev <= '0;
    ics_bus_peer_inst.close_frame();
    $display("test line done");
    wr(8'h1C, 8'hA0);
    pulse('{addr_rx: 1'b1, rx_byte: 8'hA1, default: '0});
    repeat (2) @(posedge clock);
    check("scl_oe", {7'h00, scl_oe}, 8'h01);
    check("scl_out", {7'h00, scl_out}, 8'h00);
    check("irq", {7'h00, irq}, 8'h01);
    rd(R1, 8'h84, "slave_addr_match");
    rd(R1, 8'h00, "slave_addr_match clr");
    wr(8'h1C, 8'h01);
    pulse('{addr_rx: 1'b1, rx_byte: 8'h01, default: '0});
    rd(R1, 8'h00, "addr 01");
    wr(8'h1C, 8'hA0);
    rd(8'h1C, 8'hA0, "own addr");
    ics_bus_peer_inst.open_frame();
    pulse('{addr_rx: 1'b1, rx_byte: 8'h00, default: '0});
    rd(R2, 8'h01, "broadcast_addr_seen");
    rd(R1, 8'h94, "gc slave_addr_match");
    ics_bus_peer_inst.close_frame();
    repeat (8) @(posedge clock);
    check("scl_oe", {7'h00, scl_oe}, 8'h00);
    rd(R2, 8'h08, "bus_end_detected");
    rd(R2, 8'h00, "bus_end_detected clr");
    $display("test slave done");
    wr(RC, 8'h3D);
    rd(R1, 8'h02, "master");
    pulse('{start_sent: 1'b1, default: '0});
    rd(RC, 8'h35, "start clr");
    rd(R1, 8'h83, "sb");
    wr(RD, 8'hA0);
    rd(R1, 8'h02, "sb clr");
    pulse('{byte_done: 1'b1, byte_sent: 1'b1, default: '0});
    rd(R1, 8'hAA, "btf tx");
    wr(RD, 8'h66);
    rd(R1, 8'h02, "btf clr");
    pulse('{hdr_sent: 1'b1, default: '0});
    rd(R1, 8'hC2, "hdr");
    check("scl_oe hdr", {7'h00, scl_oe}, 8'h01);
    rd(R2, 8'h00, "hdr s2");
    wr(RD, 8'h78);
    rd(R1, 8'h02, "hdr clr");
    pulse('{addr_sent: 1'b1, default: '0});
    rd(R1, 8'h82, "post addr");
    check("scl_oe ev6", {7'h00, scl_oe}, 8'h01);
    wr(RC, 8'h35);
    rd(R1, 8'h02, "post addr clr");
    wr(RC, 8'h37);
    pulse('{stop_sent: 1'b1, default: '0});
    rd(RC, 8'h35, "stop clr");
    $display("test master done");
    pulse('{nack: 1'b1, default: '0});
    repeat (2) @(posedge clock);
    check("scl_oe", {7'h00, scl_oe}, 8'h00);
    check("irq", {7'h00, irq}, 8'h01);
    rd(R2, 8'h10, "af");
    rd(R2, 8'h00, "af clr");
    pulse('{arb_lost: 1'b1, ack_slot_rx: 1'b1, default: '0});
    rd(R2, 8'h00, "lost_contention ack slot");
    pulse('{arb_lost: 1'b1, default: '0});
    rd(R1, 8'h80, "lost_contention slave");
    rd(R2, 8'h04, "lost_contention");
    rd(R1, 8'h00, "evf clr");
    $display("test error done");
    wr(RC, 8'h37);
    pulse('{byte_done: 1'b1, rx_byte: 8'h5A, default: '0});
    repeat (2) @(posedge clock);
    check("release", {7'h00, ctl.release_lines}, 8'h01);
    rd(R1, 8'h88, "btf rx");
    rd(RD, 8'h5A, "rx data");
    rd(R1, 8'h00, "btf rx clr");
    wr(RC, 8'h02);
    rd(RC, 8'h02, "cr off");
    rd(R1, 8'h00, "s1 off");
    ics_bus_peer_inst.open_frame();
    repeat (8) @(posedge clock);
    rd(R1, 8'h00, "busy off");
    ics_bus_peer_inst.close_frame();
    $display("test disable done");
    give_verdict();
  end
endmodule : test_ics_regs
`default_nettype wire
